// ===== design/sfdp_filter.sv
`timescale 1ns/1ns
module sfdp_filter #(
  parameter int CYC = 1
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire logic ce_i, // Clock enable
  input wire logic raw_i, // Synchronised comparator level
  output logic filt_o, // Level held longer than CYC cycles
  output logic pend_o // Level seen but not yet confirmed
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt, next_cnt;
  logic next_filt;

  always_comb
  begin
    next_cnt = cnt;
    next_filt = filt_o;
    if (!raw_i)
    begin
      next_cnt = '0;
      next_filt = 1'b0;
    end
    else if (cnt == CW'(CYC))
      next_filt = 1'b1;
    else
      next_cnt = cnt + 1'b1;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= '0;
      filt_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt <= next_cnt;
      filt_o <= next_filt;
    end
  end

  assign pend_o = raw_i & ~filt_o;
endmodule // sfdp_filter

// ===== design/sfdp_pkg.sv
package sfdp_pkg;
`include "sfdp_regs.svh"

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } sfdp_spi_t;

  // Raw comparator levels from the analog monitors
  typedef struct packed {
    logic ov;
    logic uv;
    logic cp;
    logic por;
    logic oc;
    logic ot;
  } sfdp_mon_t;

  typedef struct packed {
    logic frame_err;
    logic por;
    logic fault;
    logic ov;
    logic uv;
    logic overcurrent_flag;
    logic overtemp_flag;
    logic cp;
  } sfdp_faults_t;

  typedef enum logic [2:0] {
    OWN_SLEEP,
    OWN_DRIVER_DISABLE_IN,
    OWN_TSD,
    OWN_OCP,
    OWN_UV,
    OWN_IN,
    OWN_CURRENT_LIMIT_REGULATION
  } sfdp_owner_t;

  function automatic logic sfdp_addr_ok(input logic [5:0] a);
    sfdp_addr_ok = (a == `SFDP_A_ID) || (a == `SFDP_A_FSUM) ||
                   (a == `SFDP_A_STAT1) || (a == `SFDP_A_STAT2) ||
                   (a == `SFDP_A_CMD) || (a == `SFDP_A_SPIIN) ||
                   (a == `SFDP_A_CFG1);
  endfunction
endpackage

// ===== design/sfdp_regs.svh
`ifndef SFDP_REGS_SVH
`define SFDP_REGS_SVH
`define SFDP_A_ID 6'h00
`define SFDP_A_FSUM 6'h01
`define SFDP_A_STAT1 6'h02
`define SFDP_A_STAT2 6'h03
`define SFDP_A_CMD 6'h08
`define SFDP_A_SPIIN 6'h09
`define SFDP_A_CFG1 6'h0a
`define SFDP_CMD_RST 8'h00
`define SFDP_SPIIN_RST 8'h00
`define SFDP_CFG1_RST 8'h00
`define SFDP_CMD_CLR 7
`define SFDP_CFG1_OLA_EN 7
`define SFDP_CFG1_OVSEL 6:5
`define SFDP_CFG1_OCP_RETRY 3
`define SFDP_CFG1_TSD_RETRY 2
`define SFDP_CFG1_OV_RETRY 1
`define SFDP_CFG1_OLA_RETRY 0
`define SFDP_OV_OFF 2'h3
`define SFDP_STAT_HI 2'h3
`define SFDP_FRAME_BITS 6'h10
`define SFDP_CMD_BITS 6'h07
`define SFDP_OLA_CNT 2'h3
`define SFDP_CLK_NS 40
`define SFDP_T_OV_NS 10000
`define SFDP_T_UV_NS 10000
`define SFDP_T_CP_NS 10000
`define SFDP_T_POR_NS 10000
`define SFDP_T_OC_NS 4000
`define SFDP_T_OT_NS 10000
`define SFDP_CYC(ns) (((ns) + `SFDP_CLK_NS - 1) / `SFDP_CLK_NS)
`endif

// ===== design/sfdp_sync.sv
`timescale 1ns/1ns
module sfdp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire logic ce_i, // Clock enable
  input wire logic [W-1:0] d_i, // Asynchronous levels
  output logic [W-1:0] q_o // Synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else if (ce_i)
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // sfdp_sync

// ===== design/sfdp_top.sv
`timescale 1ns/1ns
`include "sfdp_regs.svh"
// Overview of operation
// - Three missed recirculation spikes flag open load
// - Retry clears after three spikes; latch holds
// - Open-load monitor disableable, high-side loads only
// - Filtered supply-high flags error, output untouched
// - Supply-low floats output and sense, retry on recovery
// - Supply-low latch only on external-supply variant
// - Filtered pump-low flags error, always retries
// - Logic-supply drop resets; report reset on recovery
// - Fixed priority grants output control
// - Pending overcurrent may hold lower events
// - Word is command+data in, status+report out
// - Select high: ignore clock/data, float output
// - Drive on rising edge, sample on falling
// - Most significant bit first both ways
// - Only sixteen clocks valid, else frame error
// - Command bit 15 zero marks standard frame
// - Bit 14 read/write, bits 13:8 address
// - Data byte written; ignored on read
// - Status byte: two ones then six flags
// - Report returns register value before write
// - Error pin is inverse of summary fault
// - Logs cleared only by clear, sleep or logic-supply reset
// - Unmapped address blocked, sets frame error
module sfdp_top #(
  parameter logic [7:0] DEV_ID = 8'h5a // Arbitrary identity value
) (
  input wire logic clk_sys_i, // 25 MHz system clock
  input wire logic rst_i, // Async reset, active high
  input wire logic ce_i, // Clock enable, freezes all state
  input wire sfdp_pkg::sfdp_spi_t spi_i, // Select, clock, data pins
  output logic sdo_o, // Serial data out
  output logic sdo_oe_o, // Serial data out enable
  input wire sfdp_pkg::sfdp_mon_t mon_i, // Raw monitor comparators
  input wire logic sleep_n_i, // Sleep request pin, low sleeps
  input wire logic driver_disable_in_i, // Driver-off pin
  input wire logic in_i, // Output command pin
  input wire logic current_limit_regulation_i, // Trip PWM chop
  input wire logic hs_load_i, // High-side load wiring
  input wire logic recirc_i, // Recirculation dead-time marker
  input wire logic spike_i, // Output spike above supply seen
  input wire logic variant_ext_i, // External logic supply variant
  input wire logic uv_latch_i, // Supply-low latch request
  output logic error_pin_n_o, // Error pin level, low = error
  output logic error_pin_oe_o, // Error pin pull-down enable
  output logic out_en_o, // Half-bridge output driven
  output logic out_level_o, // Half-bridge output level
  output logic current_sense_pin_en_o, // Current sense active
  output logic [1:0] ov_thresh_sel_o, // Supply-high threshold
  output sfdp_pkg::sfdp_owner_t out_owner_o, // Output control owner
  output sfdp_pkg::sfdp_faults_t status_o // Logged fault summary
);
  import sfdp_pkg::*;

  localparam int FILT_CYC [6] = '{`SFDP_CYC(`SFDP_T_OV_NS),
    `SFDP_CYC(`SFDP_T_UV_NS), `SFDP_CYC(`SFDP_T_CP_NS),
    `SFDP_CYC(`SFDP_T_POR_NS), `SFDP_CYC(`SFDP_T_OC_NS),
    `SFDP_CYC(`SFDP_T_OT_NS)};

  logic [17:0] raw, s;
  logic s_sel, s_cs, s_sclk, s_sdi, s_rec, s_spk, s_sleep_n, s_driver_disable_in;
  logic s_in, s_current_limit_regulation, s_hs, s_var, s_uvl;
  logic [5:0] mon_s, filt, pend;

  // Select goes through inverted so a reset synchroniser reads it as idle
  assign raw = {~spi_i.cs_n, spi_i.sclk, spi_i.sdi, mon_i, recirc_i,
    spike_i, sleep_n_i, driver_disable_in_i, in_i,
    current_limit_regulation_i, hs_load_i, variant_ext_i, uv_latch_i};

  sfdp_sync #(.W(18)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(raw),
    .q_o(s)
  );

  assign {s_sel, s_sclk, s_sdi, mon_s, s_rec, s_spk, s_sleep_n, s_driver_disable_in,
    s_in, s_current_limit_regulation, s_hs, s_var, s_uvl} = s;
  assign s_cs = ~s_sel;

  // Bit order of filt: ov, uv, cp, por, oc, ot
  for (genvar g = 0; g < 6; g++)
  begin : g_filt
    sfdp_filter #(.CYC(FILT_CYC[5 - g])) u_filt (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .raw_i(mon_s[g]),
      .filt_o(filt[g]),
      .pend_o(pend[g])
    );
  end

  wire f_ov = filt[5];
  wire f_uv = filt[4];
  wire f_cp = filt[3];
  wire f_por = filt[2];
  wire f_oc = filt[1];
  wire f_ot = filt[0];

  // Serial frame engine
  logic cs_p, sclk_p, next_cs_p, next_sclk_p;
  logic [5:0] bitcnt, next_bitcnt;
  logic [15:0] rx, tx, next_rx, next_tx;
  logic next_sdo, next_sdo_oe;
  logic cs_rise, frame_ok, wr_go, ferr_set;
  logic [7:0] rd_val;
  logic [5:0] rd_addr;

  assign cs_rise = s_cs & ~cs_p;
  assign frame_ok = (bitcnt == `SFDP_FRAME_BITS) && !rx[15] &&
                    sfdp_addr_ok(rx[13:8]);
  assign wr_go = cs_rise & frame_ok & ~rx[14];
  assign ferr_set = cs_rise & ~frame_ok;
  assign rd_addr = {rx[4:0], s_sdi};

  always_comb
  begin
    next_cs_p = s_cs;
    next_sclk_p = s_sclk;
    next_bitcnt = bitcnt;
    next_rx = rx;
    next_tx = tx;
    next_sdo = sdo_o;
    next_sdo_oe = sdo_oe_o;
    if (s_cs)
    begin
      next_sdo_oe = 1'b0;
    end
    else if (cs_p)
    begin
      // Flags frozen here so a mid-frame event cannot tear the byte
      next_tx = {`SFDP_STAT_HI, status_o.fault, status_o.ov,
                 status_o.uv, status_o.overcurrent_flag, status_o.overtemp_flag,
                 status_o.frame_err, 8'h00};
      next_bitcnt = '0;
      next_sdo = 1'b1;
      next_sdo_oe = 1'b1;
    end
    else if (s_sclk && !sclk_p)
    begin
      next_sdo = tx[15];
      next_tx = {tx[14:0], 1'b0};
    end
    else if (!s_sclk && sclk_p)
    begin
      next_rx = {rx[14:0], s_sdi};
      if (bitcnt != 6'h3f)
        next_bitcnt = bitcnt + 1'b1;
      if (bitcnt == `SFDP_CMD_BITS)
        next_tx[15:8] = rd_val;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_p <= 1'b1;
      sclk_p <= 1'b0;
      bitcnt <= '0;
      rx <= '0;
      tx <= '0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cs_p <= next_cs_p;
      sclk_p <= next_sclk_p;
      bitcnt <= next_bitcnt;
      rx <= next_rx;
      tx <= next_tx;
      sdo_o <= next_sdo;
      sdo_oe_o <= next_sdo_oe;
    end
  end

  // Registers, fault monitors and output control
  logic [7:0] cmd_r, spiin_r, cfg1, next_cmd, next_spiin, next_cfg1;
  sfdp_faults_t next_log;
  logic ov_act, uv_act, cp_act, oc_act, ot_act, ola_act, por_p;
  logic next_ov, next_uv, next_cp, next_oc, next_ot, next_ola;
  logic [1:0] miss, hit, next_miss, next_hit;
  logic rec_p, next_rec_p, next_err_n, next_en, next_lvl, next_sense;
  sfdp_owner_t next_owner;
  logic awake, active, clr, ola_on, any_act;

  assign awake = s_sleep_n;
  assign active = awake & ~s_driver_disable_in;
  assign clr = (wr_go && rx[13:8] == `SFDP_A_CMD && rx[`SFDP_CMD_CLR]) ||
               !awake;
  assign ola_on = active & cfg1[`SFDP_CFG1_OLA_EN] & s_hs;
  assign any_act = ov_act | uv_act | cp_act | oc_act | ot_act | ola_act;
  assign ov_thresh_sel_o = cfg1[`SFDP_CFG1_OVSEL];

  always_comb
  begin
    unique case (rd_addr)
      `SFDP_A_ID: rd_val = DEV_ID;
      `SFDP_A_FSUM: rd_val = status_o;
      `SFDP_A_STAT1: rd_val = {ola_act, ola_act, s_current_limit_regulation, active, 4'h0};
      `SFDP_A_STAT2: rd_val = {s_driver_disable_in, 2'h0, active, 4'h0};
      `SFDP_A_CMD: rd_val = {1'b0, cmd_r[6:0]};
      `SFDP_A_SPIIN: rd_val = spiin_r;
      `SFDP_A_CFG1: rd_val = cfg1;
      default: rd_val = 8'h00;
    endcase
  end

  always_comb
  begin
    next_cmd = cmd_r;
    next_spiin = spiin_r;
    next_cfg1 = cfg1;
    next_rec_p = s_rec;
    next_miss = miss;
    next_hit = hit;
    if (wr_go)
    begin
      unique case (rx[13:8])
        `SFDP_A_CMD: next_cmd = {1'b0, rx[6:0]};
        `SFDP_A_SPIIN: next_spiin = rx[7:0];
        `SFDP_A_CFG1: next_cfg1 = rx[7:0];
        default: ;
      endcase
    end
    // Supply-high leaves the output alone; only the pin and the status log report it
    next_ov = awake && cfg1[`SFDP_CFG1_OVSEL] != `SFDP_OV_OFF &&
              (f_ov || (ov_act && !cfg1[`SFDP_CFG1_OV_RETRY] && !clr));
    // Retry follows the supply alone, no retry timer involved
    next_uv = awake && (f_uv || (uv_act && s_var && s_uvl &&
              !clr));
    next_cp = active & f_cp;
    next_oc = active && (f_oc ||
              (oc_act && !cfg1[`SFDP_CFG1_OCP_RETRY] && !clr));
    next_ot = awake && (f_ot ||
              (ot_act && !cfg1[`SFDP_CFG1_TSD_RETRY] && !clr));
    next_ola = ola_act && !clr && awake && cfg1[`SFDP_CFG1_OLA_EN];
    if (!ola_on)
    begin
      next_miss = '0;
      next_hit = '0;
    end
    else if (s_rec && !rec_p)
    begin
      if (s_spk)
      begin
        next_miss = '0;
        next_hit = (hit == `SFDP_OLA_CNT) ? hit : hit + 1'b1;
        if (next_hit == `SFDP_OLA_CNT && cfg1[`SFDP_CFG1_OLA_RETRY])
          next_ola = 1'b0;
      end
      else
      begin
        next_hit = '0;
        next_miss = (miss == `SFDP_OLA_CNT) ? miss : miss + 1'b1;
        if (next_miss == `SFDP_OLA_CNT)
          next_ola = 1'b1;
      end
    end
    // Set wins over clear for every logged bit
    next_log = status_o & ~{8{clr}};
    next_log.frame_err = next_log.frame_err | ferr_set;
    next_log.por = next_log.por | (por_p & ~f_por);
    next_log.ov = next_log.ov | ov_act;
    next_log.uv = next_log.uv | uv_act;
    next_log.overcurrent_flag = next_log.overcurrent_flag | oc_act;
    next_log.overtemp_flag = next_log.overtemp_flag | ot_act;
    next_log.cp = next_log.cp | cp_act;
    next_log.fault = any_act | next_log.por;
    next_err_n = ~(awake & status_o.fault);
    next_owner = out_owner_o;
    next_en = out_en_o;
    next_lvl = out_level_o;
    next_sense = current_sense_pin_en_o;
    if (!awake)
    begin
      next_owner = OWN_SLEEP;
      next_en = 1'b0;
      next_sense = 1'b0;
    end
    else if (s_driver_disable_in)
    begin
      next_owner = OWN_DRIVER_DISABLE_IN;
      next_en = 1'b0;
      next_sense = 1'b1;
    end
    else if (ot_act)
    begin
      next_owner = OWN_TSD;
      next_en = 1'b0;
      next_sense = 1'b0;
    end
    else if (oc_act)
    begin
      next_owner = OWN_OCP;
      next_en = 1'b0;
      next_sense = 1'b1;
    end
    else if (pend[1])
    begin
      // Hold the lower-priority owner until the overcurrent resolves
      next_owner = out_owner_o;
    end
    else if (uv_act)
    begin
      next_owner = OWN_UV;
      next_en = 1'b0;
      next_sense = 1'b0;
    end
    else if (s_in && s_current_limit_regulation)
    begin
      next_owner = OWN_CURRENT_LIMIT_REGULATION;
      next_en = 1'b1;
      next_lvl = 1'b0;
      next_sense = 1'b1;
    end
    else
    begin
      next_owner = OWN_IN;
      next_en = 1'b1;
      next_lvl = s_in;
      next_sense = 1'b1;
    end
    if (f_por)
    begin
      next_cmd = `SFDP_CMD_RST;
      next_spiin = `SFDP_SPIIN_RST;
      next_cfg1 = `SFDP_CFG1_RST;
      {next_ov, next_uv, next_cp, next_oc, next_ot, next_ola} = '0;
      next_miss = '0;
      next_hit = '0;
      next_log = '0;
      next_err_n = 1'b1;
      next_owner = OWN_SLEEP;
      next_en = 1'b0;
      next_sense = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_r <= `SFDP_CMD_RST;
      spiin_r <= `SFDP_SPIIN_RST;
      cfg1 <= `SFDP_CFG1_RST;
      {ov_act, uv_act, cp_act, oc_act, ot_act, ola_act} <= '0;
      por_p <= 1'b0;
      miss <= '0;
      hit <= '0;
      rec_p <= 1'b0;
      status_o <= '0;
      error_pin_n_o <= 1'b1;
      out_owner_o <= OWN_SLEEP;
      out_en_o <= 1'b0;
      out_level_o <= 1'b0;
      current_sense_pin_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cmd_r <= next_cmd;
      spiin_r <= next_spiin;
      cfg1 <= next_cfg1;
      {ov_act, uv_act, cp_act, oc_act, ot_act, ola_act} <=
        {next_ov, next_uv, next_cp, next_oc, next_ot, next_ola};
      por_p <= f_por;
      miss <= next_miss;
      hit <= next_hit;
      rec_p <= next_rec_p;
      status_o <= next_log;
      error_pin_n_o <= next_err_n;
      out_owner_o <= next_owner;
      out_en_o <= next_en;
      out_level_o <= next_lvl;
      current_sense_pin_en_o <= next_sense;
    end
  end

  assign error_pin_oe_o = ~error_pin_n_o;
endmodule // sfdp_top

// ===== test/sfdp_spi_ctrl.sv
`timescale 1ns/1ns
module sfdp_spi_ctrl
  import sfdp_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic sdo_i, // Device serial output
  output sfdp_pkg::sfdp_spi_t spi_o // Select, clock, data
);
  initial spi_o = 3'b101;

  // Clock stands low outside frames; half period is four system clocks
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    spi_o.cs_n = 1'b0; // Clock low at select edge
    repeat (4) @(posedge clk_sys_i);
    #1;
    for (int i = 0; i < n; i++)
    begin
      spi_o.sclk = 1'b1;
      spi_o.sdi = tx[15 - (i % 16)];
      repeat (4) @(posedge clk_sys_i);
      #1;
      rx = {rx[14:0], sdo_i}; // Taken before the falling edge
      spi_o.sclk = 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1;
    end
    spi_o.cs_n = 1'b1;
    // A released data line must not keep showing the last bit
    spi_o.sdi = ~spi_o.sdi;
    repeat (6) @(posedge clk_sys_i); // Select high between words
    #1;
  endtask
endmodule // sfdp_spi_ctrl

// ===== test/sfdp_top_asserts.sv
`timescale 1ns/1ns
module sfdp_top_asserts
  import sfdp_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire sfdp_pkg::sfdp_spi_t spi_i, // Select, clock, data pins
  input wire logic sdo_o, // Serial data out
  input wire logic sdo_oe_o, // Serial data out enable
  input wire sfdp_pkg::sfdp_mon_t mon_i, // Raw monitor levels
  input wire logic sleep_n_i, // Sleep request pin
  input wire logic driver_disable_in_i, // Driver-off pin
  input wire logic error_pin_n_o, // Error pin level
  input wire logic out_en_o, // Output driven
  input wire logic current_sense_pin_en_o, // Current sense active
  input wire logic [1:0] ov_thresh_sel_o, // Supply-high threshold
  input wire sfdp_pkg::sfdp_owner_t out_owner_o, // Output owner
  input wire sfdp_pkg::sfdp_faults_t status_o // Logged faults
);
  logic [8:0] uv_cnt, next_uv_cnt, ov_cnt, next_ov_cnt;
  logic [5:0] nclk, next_nclk;
  logic [3:0] age, next_age;
  logic sclk_d, cs_d;

  // Fault and age counters saturate so a long fault never wraps back below the bound
  always_comb
  begin
    next_uv_cnt = mon_i.uv ? uv_cnt + 9'(uv_cnt != 9'h1ff) : 9'h000;
    next_ov_cnt = mon_i.ov ? ov_cnt + 9'(ov_cnt != 9'h1ff) : 9'h000;
    next_nclk = spi_i.cs_n ? 6'h00 : nclk + 6'(spi_i.sclk && !sclk_d);
    next_age = age + 4'(age != 4'hf);
    if ((spi_i.cs_n && !cs_d) || !sleep_n_i || mon_i.por)
      next_age = 4'h0;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      {uv_cnt, ov_cnt, nclk, age, sclk_d, cs_d} <= '0;
    else
      {uv_cnt, ov_cnt, nclk, age, sclk_d, cs_d} <=
        {next_uv_cnt, next_ov_cnt, next_nclk, next_age, spi_i.sclk,
         spi_i.cs_n};
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_sel_fall;
    $fell(spi_i.cs_n);
  endsequence
  sequence s_bad_end;
    $rose(spi_i.cs_n) && (nclk != 6'h10);
  endsequence

  err_pin_a: assert property (1'b1 |=> error_pin_n_o == !$past(status_o.fault))
    else $error("error pin does not follow fault flag");
  oe_idle_a: assert property (spi_i.cs_n [*4] |-> !sdo_oe_o)
    else $error("serial out driven while deselected");
  status_lead_a: assert property (s_sel_fall |-> ##3 sdo_oe_o && sdo_o)
    else $error("status byte does not lead with one");
  frame_err_a: assert property (s_bad_end |-> ##[1:6] status_o.frame_err)
    else $error("bad clock count not flagged");
  log_hold_a: assert property (|($past(status_o) & ~status_o & 8'hdf) |-> age < 4'h8)
    else $error("logged fault dropped without clear");
  uv_float_a: assert property (uv_cnt > 9'h10e |-> !out_en_o && !current_sense_pin_en_o)
    else $error("output not floated on supply low");
  ov_flag_a: assert property (ov_cnt > 9'h10e && ov_thresh_sel_o != 2'h3 |-> status_o.ov && !error_pin_n_o)
    else $error("supply high not flagged");
  sleep_own_a: assert property (!sleep_n_i [*5] |-> out_owner_o == OWN_SLEEP)
    else $error("sleep does not own output");
  driver_disable_in_own_a: assert property ((sleep_n_i && driver_disable_in_i) [*5] |-> out_owner_o == OWN_DRIVER_DISABLE_IN)
    else $error("driver off does not own output");
endmodule // sfdp_top_asserts
bind sfdp_top sfdp_top_asserts u_chk (.*);

// ===== test/sfdp_top_bench.sv
`timescale 1ns/1ns
module sfdp_top_bench;
  import sfdp_pkg::*;
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin \
  num_errors++; $display("MISMATCH %0t %s", $time, m); end end
  logic clk = 1'b0, rst = 1'b1, slp_n = 1'b1, drv_off = 1'b0;
  logic in_p = 1'b1, hs = 1'b0, recirc = 1'b0, spike = 1'b0;
  logic var_ext = 1'b0, uv_lat = 1'b0;
  sfdp_mon_t mon = '0;
  sfdp_spi_t spi;
  wire logic sdo_w;
  logic sdo, sdo_oe, err_n, err_oe, out_en, out_lvl, sense;
  logic [1:0] ov_sel;
  sfdp_owner_t owner;
  sfdp_faults_t st;
  logic [15:0] rx;
  logic [7:0] prev, d;
  int num_errors = 0, n_checks = 0, cyc = 0;

  assign sdo_w = sdo_oe ? sdo : 1'bz;
  always #20 clk = ~clk;

  sfdp_top u_dut (.clk_sys_i(clk), .rst_i(rst), .ce_i(1'b1), .spi_i(spi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .mon_i(mon), .sleep_n_i(slp_n),
    .driver_disable_in_i(drv_off), .in_i(in_p),
    .current_limit_regulation_i(1'b0), .hs_load_i(hs), .recirc_i(recirc),
    .spike_i(spike), .variant_ext_i(var_ext), .uv_latch_i(uv_lat),
    .error_pin_n_o(err_n), .error_pin_oe_o(err_oe), .out_en_o(out_en),
    .out_level_o(out_lvl), .current_sense_pin_en_o(sense),
    .ov_thresh_sel_o(ov_sel), .out_owner_o(owner), .status_o(st));
  sfdp_spi_ctrl u_ctrl (.clk_sys_i(clk), .sdo_i(sdo_w), .spi_o(spi));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic frame(input logic rd, input logic [5:0] a,
                       input logic [7:0] dv);
    u_ctrl.xfer({1'b0, rd, a, dv}, 16, rx);
  endtask
  task automatic pulses(input logic sp, input int n);
    repeat (n)
    begin
      spike = sp;
      tick(2);
      recirc = 1'b1;
      tick(4);
      recirc = 1'b0;
      tick(6);
    end
  endtask
  function automatic logic [7:0] sbyte(input logic f, ov, uv, fe);
    return {2'b11, f, ov, uv, 2'b00, fe};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // About twice the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("MISMATCH %0t run too long", $time);
      end_sim();
    end
  end

  initial
  begin
    void'($urandom(32'h08f4));
    tick(20);
    rst = 1'b0;
    tick(4);
    `CHK(err_n, 1'b1, "pin after reset")
    prev = 8'h00;
    repeat (6)
    begin
      d = $urandom;
      frame(1'b0, 6'h09, d);
      `CHK(rx, {sbyte(1'b0, 1'b0, 1'b0, 1'b0), prev}, "write")
      frame(1'b1, 6'h09, ~d);
      `CHK(rx[7:0], d, "read back")
      prev = d;
    end
    $display("test registers finished");
    frame(1'b1, 6'h20, 8'h00);
    `CHK(rx, 16'hc000, "unmapped read")
    // Short, long, extended-type and unmapped writes are all dropped
    for (int i = 0; i < 4; i++)
    begin
      u_ctrl.xfer({i == 2, 1'b0, (i == 3) ? 6'h3f : 6'h09, ~prev},
                  (i == 0) ? 15 : ((i == 1) ? 17 : 16), rx);
      frame(1'b1, 6'h09, 8'h00);
      `CHK(rx, {sbyte(1'b0, 1'b0, 1'b0, 1'b1), prev}, "bad frame")
      frame(1'b0, 6'h08, 8'h80);
    end
    frame(1'b1, 6'h09, 8'h00);
    `CHK(rx[15:8], sbyte(1'b0, 1'b0, 1'b0, 1'b0), "cleared")
    $display("test framing finished");
    for (int s = 0; s < 4; s++)
    begin
      frame(1'b0, 6'h0a, {1'b0, 2'(s), 5'h02});
      `CHK(ov_sel, 2'(s), "threshold select")
      mon.ov = 1'b1;
      tick(300);
      frame(1'b1, 6'h01, 8'h00);
      `CHK(rx[15:8], sbyte(s != 3, s != 3, 1'b0, 1'b0), "ov byte")
      mon.ov = 1'b0;
      tick(10);
      `CHK(st.ov, s != 3, "ov log held")
      frame(1'b0, 6'h08, 8'h80);
    end
    $display("test supply high finished");
    frame(1'b0, 6'h0a, 8'h81);
    for (int h = 0; h < 2; h++)
    begin
      hs = h[0];
      pulses(1'b0, 2);
      `CHK(err_n, 1'b1, "two misses")
      pulses(1'b0, 1);
      `CHK(err_n, !hs, "open load")
      `CHK(err_oe, hs, "pin pull-down")
    end
    frame(1'b1, 6'h02, 8'h00);
    `CHK(rx[7:6], 2'b11, "open load status")
    pulses(1'b1, 3);
    `CHK(err_n, 1'b1, "open load retry")
    $display("test open load finished");
    frame(1'b1, 6'h20, 8'h00);
    `CHK(owner, OWN_IN, "input owner")
    `CHK({out_en, out_lvl}, 2'b11, "input drives")
    drv_off = 1'b1;
    tick(8);
    `CHK(owner, OWN_DRIVER_DISABLE_IN, "driver off owner")
    slp_n = 1'b0;
    tick(8);
    `CHK(owner, OWN_SLEEP, "sleep owner")
    `CHK(st, 8'h00, "sleep clears log")
    slp_n = 1'b1;
    drv_off = 1'b0;
    tick(8);
    $display("test priority finished");
    for (int v = 0; v < 2; v++)
    begin
      var_ext = v[0];
      uv_lat = 1'b1;
      mon.uv = 1'b1;
      tick(300);
      `CHK(st.uv, 1'b1, "supply low log")
      mon.uv = 1'b0;
      tick(10);
      `CHK(err_n, !var_ext, "supply low reaction")
      frame(1'b0, 6'h08, 8'h80);
    end
    mon.cp = 1'b1;
    tick(300);
    `CHK({err_n, out_en, st.cp}, 3'b011, "pump low")
    mon.cp = 1'b0;
    tick(10);
    `CHK(err_n, 1'b1, "pump retry")
    frame(1'b0, 6'h08, 8'h80);
    mon.por = 1'b1;
    tick(300);
    `CHK({err_n, out_en, sense}, 3'b100, "during reset")
    mon.por = 1'b0;
    tick(6);
    `CHK({st.por, err_n}, 2'b10, "reset reported")
    frame(1'b1, 6'h09, 8'h00);
    `CHK(rx[7:0], 8'h00, "register reset")
    $display("test power finished");
    end_sim();
  end
endmodule // sfdp_top_bench
